// [pkg/bmd_pkg.sv]
/*
  Constants and carrier types for the byte-wide instruction decoder core.
  Assumes an APB master with 32-bit data and a register file that answers
  a read strobe with data on the following clock.
*/
package bmd_pkg;

  // Instruction word and its classes
  localparam int          INSTR_W      = 14;
  localparam logic [1:0]  CLS_BYTE     = 2'h0;
  localparam logic [1:0]  CLS_BIT      = 2'h1;
  localparam logic [1:0]  CLS_BRANCH   = 2'h2;
  localparam logic [1:0]  CLS_LITERAL  = 2'h3;

  // Byte-oriented opcodes, bits 11:8
  localparam logic [3:0]  OP_STORE_CTL = 4'h0;
  localparam logic [3:0]  OP_CLEAR     = 4'h1;
  localparam logic [3:0]  OP_SUB       = 4'h2;
  localparam logic [3:0]  OP_DEC       = 4'h3;
  localparam logic [3:0]  OP_OR        = 4'h4;
  localparam logic [3:0]  OP_AND       = 4'h5;
  localparam logic [3:0]  OP_XOR       = 4'h6;
  localparam logic [3:0]  OP_ADD       = 4'h7;
  localparam logic [3:0]  OP_MOVE      = 4'h8;
  localparam logic [3:0]  OP_COMP      = 4'h9;
  localparam logic [3:0]  OP_INC       = 4'hA;
  localparam logic [3:0]  OP_DEC_SKIP  = 4'hB;
  localparam logic [3:0]  OP_ROT_RIGHT = 4'hC;
  localparam logic [3:0]  OP_ROT_LEFT  = 4'hD;
  localparam logic [3:0]  OP_SWAP      = 4'hE;
  localparam logic [3:0]  OP_INC_SKIP  = 4'hF;

  // Control words under byte opcode zero, bits 7:0
  localparam logic [7:0]  CTL_RETURN   = 8'h08;
  localparam logic [7:0]  CTL_INT_RET  = 8'h09;
  localparam logic [7:0]  CTL_STANDBY  = 8'h63;
  localparam logic [7:0]  CTL_WDT_CLR  = 8'h64;

  // Bit-oriented sub-opcodes, bits 11:10
  localparam logic [1:0]  BIT_CLEAR    = 2'h0;
  localparam logic [1:0]  BIT_SET      = 2'h1;
  localparam logic [1:0]  BIT_TST_CLR  = 2'h2;
  localparam logic [1:0]  BIT_TST_SET  = 2'h3;

  // Literal opcodes, bits 11:8
  localparam logic [3:0]  LIT_OR       = 4'h8;
  localparam logic [3:0]  LIT_AND      = 4'h9;
  localparam logic [3:0]  LIT_XOR      = 4'hA;

  // Status flag positions and reset value
  localparam int          FLAG_C       = 0;
  localparam int          FLAG_DC      = 1;
  localparam int          FLAG_Z       = 2;
  localparam int          FLAG_PD      = 3;
  localparam int          FLAG_TO      = 4;
  localparam logic [4:0]  STATUS_RST   = 5'h18;

  // Register map
  localparam int          APB_AW       = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_WORK    = 12'h008;
  localparam logic [11:0] ADDR_PC      = 12'h00C;
  localparam int          CTRL_RUN     = 0;
  localparam int          CTRL_PSA_T0  = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam int          STAT_SLEEP   = 8;

  // Oscillator periods per instruction cycle
  localparam int          CLK_PER_CYC  = 4;

  typedef enum logic [3:0]
  {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } bmd_phase_type;

  typedef struct packed
  {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } bmd_apb_req_type;

  typedef struct packed
  {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bmd_apb_rsp_type;

  typedef struct packed
  {
    logic [6:0] addr;
    logic       rd;
    logic       we;
    logic [7:0] wdata;
  } bmd_rf_req_type;

endpackage

// [verilog/bmd_core.sv]
/*
  Instruction decoder and executor of a small 8-bit core, with an APB
  slave for run control and state readback.
  Assumes program memory returns the word for prog_addr one clock later,
  and the register file returns rf_rdata one clock after rf_req.rd.
*/
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps

// Operation
// - File operands always read before written back
// - File address is seven bits, 0x00-0x7F
// - Destination bit picks work or file
// - Decrement/increment skip discards next when zero
// - Byte OR, XOR, AND touch zero only
// - Rotates go through carry, carry only
// - Bit clear/set leave status alone
// - Bit tests skip on matching bit
// - Branch or true test costs NO_OPERATION cycle
// - Call and jump take 11-bit target
// - Returns pop address, two cycles
// - Return with literal loads work register
// - Literal add/subtract set C, DC, Z
// - Literal OR, AND, XOR touch zero only
// - Standby enters low power, updates TO/PD
// - Watchdog clear restarts dog, updates TO/PD
// - Don't-care opcode bits are ignored
// - Port read-modify-write uses pin levels
// - Timer write clears assigned prescaler
// - Clear file reads, writes zero, sets Z
// - Four clocks per instruction cycle
module bmd_core
#(
  parameter int         PC_W        = 13,
  parameter int         STACK_DEPTH = 8,
  parameter logic [6:0] PORT_ADDR   = 7'h06,
  parameter logic [6:0] TMR_ADDR    = 7'h01
)
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire bmd_pkg::bmd_apb_req_type apb_req,
  output bmd_pkg::bmd_apb_rsp_type      apb_rsp,
  output logic [PC_W-1:0]               prog_addr,
  input  wire logic [13:0]              prog_data,
  output bmd_pkg::bmd_rf_req_type       rf_req,
  input  wire logic [7:0]               rf_rdata,
  input  wire logic [7:0]               port_pins,
  output logic                          prescaler_clear,
  output logic                          wdt_clear,
  output logic                          sleep_mode
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  generate
    if (PC_W < 11 || STACK_DEPTH < 2 ||
        (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
    begin : g_bad_param
      $error("bmd_core: PC_W or STACK_DEPTH out of range");
    end
  endgenerate

  typedef struct packed
  {
    bmd_pkg::bmd_phase_type             phase;
    logic [13:0]                        ir;
    logic                               flush;
    logic [PC_W-1:0]                    pc;
    logic [7:0]                         w;
    logic [4:0]                         status;
    logic                               sleeping;
    logic [1:0]                         ctrl;
    logic [STACK_DEPTH-1:0][PC_W-1:0]   stack;
    logic [SP_W-1:0]                    sp;
    bmd_pkg::bmd_rf_req_type            rf;
    logic                               pre_clr;
    logic                               wdt_clr;
    bmd_pkg::bmd_apb_rsp_type           apb;
  } bmd_state_type;

  bmd_state_type s_reg;
  bmd_state_type s_next;

  // Words that name a file register; control words and clear-work do not
  function automatic logic names_file(input logic [13:0] word);
    names_file = (word[13:12] == bmd_pkg::CLS_BIT) ||
                 (word[13:12] == bmd_pkg::CLS_BYTE &&
                  !(word[11:9] == 3'h0 && !word[7]));
  endfunction

  function automatic logic is_byte_op(input logic [13:0] word,
                                      input logic [3:0]  op);
    is_byte_op = word[13:12] == bmd_pkg::CLS_BYTE && word[11:8] == op;
  endfunction

  logic [7:0]      fval;
  logic [7:0]      bmask;
  logic [7:0]      add_a;
  logic [7:0]      add_b;
  logic            sub_sel;
  logic [8:0]      sum9;
  logic [4:0]      dsum5;
  logic [SP_W-1:0] sp_dec;
  logic            exec;

  // Pin levels stand in for the port latch on every port operand
  assign fval    = (s_reg.ir[6:0] == PORT_ADDR) ? port_pins : rf_rdata;
  assign bmask   = 8'h01 << s_reg.ir[9:7];
  assign sub_sel = is_byte_op(s_reg.ir, bmd_pkg::OP_SUB) ||
                   (s_reg.ir[13:12] == bmd_pkg::CLS_LITERAL &&
                    s_reg.ir[11:9] == 3'h6);
  assign add_a   = (s_reg.ir[13:12] == bmd_pkg::CLS_LITERAL) ?
                   s_reg.ir[7:0] : fval;
  assign add_b   = sub_sel ? ~s_reg.w : s_reg.w;
  assign sum9    = {1'b0, add_a} + {1'b0, add_b} + {8'h00, sub_sel};
  assign dsum5   = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, sub_sel};
  assign sp_dec  = s_reg.sp - SP_W'(1);
  assign exec    = s_reg.phase == bmd_pkg::PH_Q3 && !s_reg.flush;

  always_comb
  begin
    logic [7:0] res;
    logic       wr_file;
    logic       wr_w;
    logic       set_z;
    logic       skip;
    logic       two;
    logic       push;
    logic       pop;
    logic       access;
    res     = 8'h00;
    wr_file = 1'b0;
    wr_w    = 1'b0;
    set_z   = 1'b0;
    skip    = 1'b0;
    two     = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    s_next  = s_reg;
    access  = apb_req.psel && apb_req.penable;

    // One wait state so that every bus answer comes from a flip-flop
    s_next.apb.pready  = 1'b0;
    s_next.apb.pslverr = 1'b0;
    if (access && !s_reg.apb.pready)
    begin
      s_next.apb.pready = 1'b1;
      s_next.apb.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        bmd_pkg::ADDR_CTRL:   s_next.apb.prdata = 32'(s_reg.ctrl);
        bmd_pkg::ADDR_STATUS: s_next.apb.prdata =
          32'(s_reg.status) | (32'(s_reg.sleeping) << bmd_pkg::STAT_SLEEP);
        bmd_pkg::ADDR_WORK:   s_next.apb.prdata = 32'(s_reg.w);
        bmd_pkg::ADDR_PC:     s_next.apb.prdata = 32'(s_reg.pc);
        default:              s_next.apb.pslverr = 1'b1;
      endcase
    end
    else if (access && apb_req.pwrite &&
             apb_req.paddr == bmd_pkg::ADDR_CTRL)
    begin
      // Any control write also wakes the core; a standby in flight wins
      s_next.ctrl     = apb_req.pwdata[1:0];
      s_next.sleeping = 1'b0;
    end

    case (s_reg.phase)
      bmd_pkg::PH_Q1:
      begin
        if (s_reg.ctrl[bmd_pkg::CTRL_RUN] && !s_reg.sleeping)
        begin
          s_next.ir      = prog_data;
          s_next.rf.addr = prog_data[6:0];
          s_next.rf.rd   = !s_reg.flush && names_file(prog_data);
          s_next.phase   = bmd_pkg::PH_Q2;
        end
      end
      bmd_pkg::PH_Q2:
      begin
        s_next.rf.rd = 1'b0;
        s_next.phase = bmd_pkg::PH_Q3;
      end
      bmd_pkg::PH_Q3:
      begin
        s_next.phase = bmd_pkg::PH_Q4;
        s_next.pc    = s_reg.pc + PC_W'(1);
        if (s_reg.flush)
        begin
          // Discarded word runs as a NO_OPERATION; the fetch address is kept
          s_next.flush = 1'b0;
          s_next.pc    = s_reg.pc;
        end
        else
        begin
          case (s_reg.ir[13:12])
            bmd_pkg::CLS_BYTE:
            begin
              wr_file = s_reg.ir[7];
              wr_w    = !s_reg.ir[7];
              case (s_reg.ir[11:8])
                bmd_pkg::OP_STORE_CTL:
                begin
                  wr_w = 1'b0;
                  res  = s_reg.w;
                  if (!s_reg.ir[7])
                  begin
                    // Unlisted control words run as NO_OPERATION
                    case (s_reg.ir[7:0])
                      bmd_pkg::CTL_RETURN, bmd_pkg::CTL_INT_RET:
                      begin
                        pop = 1'b1;
                        two = 1'b1;
                      end
                      bmd_pkg::CTL_STANDBY:
                      begin
                        s_next.status[bmd_pkg::FLAG_TO] = 1'b1;
                        s_next.status[bmd_pkg::FLAG_PD] = 1'b0;
                        s_next.sleeping = 1'b1;
                        s_next.wdt_clr  = 1'b1;
                      end
                      bmd_pkg::CTL_WDT_CLR:
                      begin
                        s_next.status[bmd_pkg::FLAG_TO] = 1'b1;
                        s_next.status[bmd_pkg::FLAG_PD] = 1'b1;
                        s_next.wdt_clr = 1'b1;
                      end
                      default: ;
                    endcase
                  end
                end
                bmd_pkg::OP_CLEAR:
                begin
                  res   = 8'h00;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_SUB, bmd_pkg::OP_ADD:
                begin
                  res = sum9[7:0];
                  s_next.status[bmd_pkg::FLAG_C]  = sum9[8];
                  s_next.status[bmd_pkg::FLAG_DC] = dsum5[4];
                  set_z = 1'b1;
                end
                bmd_pkg::OP_DEC:
                begin
                  res   = fval - 8'h01;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_INC:
                begin
                  res   = fval + 8'h01;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_OR:
                begin
                  res   = fval | s_reg.w;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_AND:
                begin
                  res   = fval & s_reg.w;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_XOR:
                begin
                  res   = fval ^ s_reg.w;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_MOVE:
                begin
                  res   = fval;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_COMP:
                begin
                  res   = ~fval;
                  set_z = 1'b1;
                end
                bmd_pkg::OP_DEC_SKIP:
                begin
                  res  = fval - 8'h01;
                  skip = res == 8'h00;
                end
                bmd_pkg::OP_INC_SKIP:
                begin
                  res  = fval + 8'h01;
                  skip = res == 8'h00;
                end
                bmd_pkg::OP_ROT_RIGHT:
                begin
                  res = {s_reg.status[bmd_pkg::FLAG_C], fval[7:1]};
                  s_next.status[bmd_pkg::FLAG_C] = fval[0];
                end
                bmd_pkg::OP_ROT_LEFT:
                begin
                  res = {fval[6:0], s_reg.status[bmd_pkg::FLAG_C]};
                  s_next.status[bmd_pkg::FLAG_C] = fval[7];
                end
                default:
                begin
                  res = {fval[3:0], fval[7:4]};
                end
              endcase
            end
            bmd_pkg::CLS_BIT:
            begin
              case (s_reg.ir[11:10])
                bmd_pkg::BIT_CLEAR:
                begin
                  res     = fval & ~bmask;
                  wr_file = 1'b1;
                end
                bmd_pkg::BIT_SET:
                begin
                  res     = fval | bmask;
                  wr_file = 1'b1;
                end
                bmd_pkg::BIT_TST_CLR: skip = (fval & bmask) == 8'h00;
                default:              skip = (fval & bmask) != 8'h00;
              endcase
            end
            bmd_pkg::CLS_BRANCH:
            begin
              push = !s_reg.ir[11];
              two  = 1'b1;
              s_next.pc[10:0] = s_reg.ir[10:0];
            end
            default:
            begin
              // Bits 9:8 of load and return-with-literal are don't-care
              if (s_reg.ir[11:10] == 2'h0)
              begin
                res  = s_reg.ir[7:0];
                wr_w = 1'b1;
              end
              else if (s_reg.ir[11:10] == 2'h1)
              begin
                res  = s_reg.ir[7:0];
                wr_w = 1'b1;
                pop  = 1'b1;
                two  = 1'b1;
              end
              else if (s_reg.ir[11:10] == 2'h3)
              begin
                res  = sum9[7:0];
                wr_w = 1'b1;
                s_next.status[bmd_pkg::FLAG_C]  = sum9[8];
                s_next.status[bmd_pkg::FLAG_DC] = dsum5[4];
                set_z = 1'b1;
              end
              else if (s_reg.ir[11:8] != 4'hB)
              begin
                wr_w  = 1'b1;
                set_z = 1'b1;
                case (s_reg.ir[11:8])
                  bmd_pkg::LIT_OR:  res = s_reg.w | s_reg.ir[7:0];
                  bmd_pkg::LIT_AND: res = s_reg.w & s_reg.ir[7:0];
                  default:          res = s_reg.w ^ s_reg.ir[7:0];
                endcase
              end
            end
          endcase

          if (set_z)
          begin
            s_next.status[bmd_pkg::FLAG_Z] = res == 8'h00;
          end
          if (wr_w)
          begin
            s_next.w = res;
          end
          if (wr_file)
          begin
            s_next.rf.we    = 1'b1;
            s_next.rf.wdata = res;
            s_next.pre_clr  = s_reg.ir[6:0] == TMR_ADDR &&
                              s_reg.ctrl[bmd_pkg::CTRL_PSA_T0];
          end
          if (push)
          begin
            s_next.stack[s_reg.sp] = s_reg.pc + PC_W'(1);
            s_next.sp              = s_reg.sp + SP_W'(1);
          end
          if (pop)
          begin
            s_next.pc = s_reg.stack[sp_dec];
            s_next.sp = sp_dec;
          end
          if (skip)
          begin
            s_next.pc = s_reg.pc + PC_W'(2);
          end
          s_next.flush = two || skip;
        end
      end
      bmd_pkg::PH_Q4:
      begin
        s_next.rf.we   = 1'b0;
        s_next.pre_clr = 1'b0;
        s_next.wdt_clr = 1'b0;
        s_next.phase   = bmd_pkg::PH_Q1;
      end
      default:
      begin
        s_next.phase = bmd_pkg::PH_Q1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg        <= '0;
      s_reg.phase  <= bmd_pkg::PH_Q1;
      s_reg.status <= bmd_pkg::STATUS_RST;
      s_reg.ctrl   <= bmd_pkg::CTRL_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp         = s_reg.apb;
  assign prog_addr       = s_reg.pc;
  assign rf_req          = s_reg.rf;
  assign prescaler_clear = s_reg.pre_clr;
  assign wdt_clear       = s_reg.wdt_clr;
  assign sleep_mode      = s_reg.sleeping;

  property p_rmw_order;
    @(posedge clk) disable iff (!nrst)
    $rose(s_reg.rf.we) |-> $past(s_reg.rf.rd, 2);
  endproperty
  a_rmw_order: assert property (p_rmw_order)
    else $error("file write without a prior read");

  property p_four_phase;
    @(posedge clk) disable iff (!nrst)
    s_reg.phase == bmd_pkg::PH_Q2 |=> s_reg.phase == bmd_pkg::PH_Q3
      ##1 s_reg.phase == bmd_pkg::PH_Q4 ##1 s_reg.phase == bmd_pkg::PH_Q1;
  endproperty
  a_four_phase: assert property (p_four_phase)
    else $error("instruction cycle is not four clocks");

  property p_dest_work;
    @(posedge clk) disable iff (!nrst)
    exec && s_reg.ir[13:12] == bmd_pkg::CLS_BYTE && !s_reg.ir[7] &&
      s_reg.ir[11:9] != 3'h0 |=> !s_reg.rf.we;
  endproperty
  a_dest_work: assert property (p_dest_work)
    else $error("work destination wrote the file");

  property p_dec_skip;
    @(posedge clk) disable iff (!nrst)
    exec && is_byte_op(s_reg.ir, bmd_pkg::OP_DEC_SKIP) &&
      fval == 8'h01 |=> s_reg.flush && s_reg.pc == $past(s_reg.pc) + PC_W'(2);
  endproperty
  a_dec_skip: assert property (p_dec_skip)
    else $error("decrement to zero did not skip");

  property p_rotate_z;
    @(posedge clk) disable iff (!nrst)
    exec && s_reg.ir[13:12] == bmd_pkg::CLS_BYTE &&
      s_reg.ir[11:9] == 3'h6 |=> $stable(s_reg.status[4:1]);
  endproperty
  a_rotate_z: assert property (p_rotate_z)
    else $error("rotate changed a flag other than carry");

  property p_bit_flags;
    @(posedge clk) disable iff (!nrst)
    exec && s_reg.ir[13:12] == bmd_pkg::CLS_BIT |=> $stable(s_reg.status);
  endproperty
  a_bit_flags: assert property (p_bit_flags)
    else $error("bit operation changed status");

  property p_jump;
    @(posedge clk) disable iff (!nrst)
    exec && s_reg.ir[13:12] == bmd_pkg::CLS_BRANCH |=>
      s_reg.flush && s_reg.pc[10:0] == $past(s_reg.ir[10:0])
      ##4 !s_reg.flush && $stable(s_reg.pc);
  endproperty
  a_jump: assert property (p_jump)
    else $error("branch target or second cycle wrong");

  property p_ret_lit;
    @(posedge clk) disable iff (!nrst)
    exec && s_reg.ir[13:10] == 4'hD |=>
      s_reg.w == $past(s_reg.ir[7:0]) && s_reg.flush;
  endproperty
  a_ret_lit: assert property (p_ret_lit)
    else $error("return with literal mishandled");

  property p_port_pins;
    @(posedge clk) disable iff (!nrst)
    exec && is_byte_op(s_reg.ir, bmd_pkg::OP_MOVE) && s_reg.ir[7] &&
      s_reg.ir[6:0] == PORT_ADDR |=> s_reg.rf.wdata == $past(port_pins);
  endproperty
  a_port_pins: assert property (p_port_pins)
    else $error("port write-back did not use pin levels");

  property p_prescale;
    @(posedge clk) disable iff (!nrst)
    s_reg.pre_clr |-> s_reg.rf.we && s_reg.rf.addr == TMR_ADDR &&
      s_reg.ctrl[bmd_pkg::CTRL_PSA_T0];
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler cleared without timer write");

  property p_standby;
    @(posedge clk) disable iff (!nrst)
    exec && s_reg.ir == 14'(bmd_pkg::CTL_STANDBY) |=>
      s_reg.sleeping && !s_reg.status[bmd_pkg::FLAG_PD] &&
      s_reg.status[bmd_pkg::FLAG_TO] && s_reg.wdt_clr;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby did not enter low power");

endmodule

// [tb/bmd_mem_model.sv]
/*
  Program memory and register file beside the core.
  Assumes words come one clock after prog_addr and reads one clock late.
*/
`timescale 1ns/100ps

module bmd_mem_model
(
  input  wire logic                    clk,
  input  wire logic [12:0]             prog_addr,
  output logic [13:0]                  prog_data,
  input  wire bmd_pkg::bmd_rf_req_type rf_req,
  output logic [7:0]                   rf_rdata
);
  logic [13:0] rom [0:31];
  logic [7:0]  rf  [0:127];

  // Output is inverted on clocks without a read, so a stale byte looks valid only every second clock.
  // Plain always: the bench preloads both arrays from outside.
  always @(posedge clk)
  begin
    prog_data <= rom[prog_addr[4:0]];
    rf_rdata  <= rf_req.rd ? rf[rf_req.addr] : ~rf_rdata;
    if (rf_req.we)
      rf[rf_req.addr] <= rf_req.wdata;
  end
endmodule

// [tb/bmd_core_tb.sv]
/*
  Self-checking bench for the core: runs a short program, checks results.
  Assumes the memory model above and the APB wait state of the core.
*/
`timescale 1ns/100ps

module bmd_core_tb;
  logic                     clk;
  logic                     nrst;
  bmd_pkg::bmd_apb_req_type apb_req;
  bmd_pkg::bmd_apb_rsp_type apb_rsp;
  logic [12:0]              prog_addr;
  logic [13:0]              prog_data;
  bmd_pkg::bmd_rf_req_type  rf_req;
  logic [7:0]               rf_rdata;
  logic [7:0]               port_pins;
  logic                     prescaler_clear;
  logic                     wdt_clear;
  logic                     sleep_mode;
  logic [31:0]              rd;
  logic                     err;
  int                       n_errors;
  int                       n_compared;
  int                       n_cyc;
  int                       n_pre;
  int                       n_wdt;

  bmd_core i_dut
  (
    .clk             (clk),
    .nrst            (nrst),
    .apb_req         (apb_req),
    .apb_rsp         (apb_rsp),
    .prog_addr       (prog_addr),
    .prog_data       (prog_data),
    .rf_req          (rf_req),
    .rf_rdata        (rf_rdata),
    .port_pins       (port_pins),
    .prescaler_clear (prescaler_clear),
    .wdt_clear       (wdt_clear),
    .sleep_mode      (sleep_mode)
  );

  bmd_mem_model i_mem
  (
    .clk       (clk),
    .prog_addr (prog_addr),
    .prog_data (prog_data),
    .rf_req    (rf_req),
    .rf_rdata  (rf_rdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ceiling far above the hundred or so cycles the tests need
  always @(posedge clk)
  begin
    n_cyc <= n_cyc + 1;
    n_pre <= n_pre + int'(prescaler_clear);
    n_wdt <= n_wdt + int'(wdt_clear);
    if (n_cyc == 3000)
    begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string m, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge clk);
    while (apb_rsp.pready !== 1'b1);
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge clk);
  endtask

  task automatic t_reset();
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status", rd, 32'h0000_0018);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
  endtask

  // Covers byte, bit, literal, skip, jump and standby forms in one run
  task automatic t_prog();
    apb(1'b1, 12'h000, 32'h0000_0003);
    repeat (1000)
      if (sleep_mode !== 1'b1)
        @(posedge clk);
    // Pulse counters update by NBA; let the standby pulse land first
    @(posedge clk);
    chk("f20", i_mem.rf[7'h20], 32'h0000_001F);
    chk("port", i_mem.rf[7'h06], 32'h0000_00A5);
    chk("pc", prog_addr, 32'h0000_000D);
    chk("f21", i_mem.rf[7'h21], 32'h0000_0080);
    chk("f22", i_mem.rf[7'h22], 32'h0000_0000);
    chk("f23", i_mem.rf[7'h23], 32'h0000_0000);
    chk("tmr", i_mem.rf[7'h01], 32'h0000_000F);
    chk("pre", n_pre, 32'h0000_0001);
    chk("wdt", n_wdt, 32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("work", rd, 32'h0000_0010);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status", rd, 32'h0000_0114);
  endtask

  initial
  begin
    nrst = 1'b0;
    apb_req = '0;
    port_pins = 8'hA5;
    n_errors = 0;
    n_compared = 0;
    n_cyc = 0;
    n_pre = 0;
    n_wdt = 0;
    for (int i = 0; i < 32; i++)
      i_mem.rom[i] = 14'h0000;
    i_mem.rf[7'h21] = 8'h00;
    i_mem.rf[7'h22] = 8'h01;
    i_mem.rf[7'h23] = 8'h77;
    i_mem.rf[7'h06] = 8'h3C;
    i_mem.rom[0]  = 14'h330F;
    i_mem.rom[1]  = 14'h00A0;
    i_mem.rom[2]  = 14'h0081;
    i_mem.rom[3]  = 14'h3F01;
    i_mem.rom[4]  = 14'h07A0;
    i_mem.rom[5]  = 14'h17A1;
    i_mem.rom[6]  = 14'h0BA2;
    i_mem.rom[7]  = 14'h3055;
    i_mem.rom[8]  = 14'h280A;
    i_mem.rom[9]  = 14'h30AA;
    i_mem.rom[10] = 14'h0886;
    i_mem.rom[11] = 14'h01A3;
    i_mem.rom[12] = 14'h0063;
    repeat (3)
      @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_prog();
    give_verdict();
  end
endmodule
